/* src/tap_pkg.sv */
// Package with TAP state encodings, instruction codes and sizes
package tap_pkg;
    localparam int IR_WIDTH = 4;
    localparam int ID_WIDTH = 32;
    localparam int BYPASS_WIDTH = 1;
    localparam int SYNC_STAGES = 2;
    // Identification value is arbitrary
    localparam logic [31:0] ID_VALUE = 32'h1234_5ABD;
    localparam logic [3:0] IR_RESET_VALUE = 4'h1;
    localparam logic [1:0] IR_CAPTURE_VALUE = 2'h1;
    localparam logic [3:0] INSTR_IDCODE = 4'h1;
    localparam logic [3:0] INSTR_BYPASS = 4'hF;
    localparam logic [3:0] INSTR_EXTEST = 4'h0;
    localparam logic [3:0] INSTR_SAMPLE = 4'h2;

    typedef enum logic [3:0] {
        ST_RESET = 4'hF,
        ST_IDLE = 4'hC,
        ST_SEL_DR = 4'h7,
        ST_CAP_DR = 4'h6,
        ST_SHIFT_DR = 4'h2,
        ST_EXIT1_DR = 4'h1,
        ST_PAUSE_DR = 4'h3,
        ST_EXIT2_DR = 4'h0,
        ST_UPD_DR = 4'h5,
        ST_SEL_IR = 4'h4,
        ST_CAP_IR = 4'hE,
        ST_SHIFT_IR = 4'hA,
        ST_EXIT1_IR = 4'h9,
        ST_PAUSE_IR = 4'hB,
        ST_EXIT2_IR = 4'h8,
        ST_UPD_IR = 4'hD
    } tap_state_type;
endpackage : tap_pkg

/* src/tap_edge_if.sv */
// Interface carrying synchronised test pins and edge strobes
`timescale 1ns/1ps
interface tap_edge_if;
    logic rise;
    logic fall;
    logic mode_select;
    logic data_in;
    logic reset_active;
    modport src (output rise, output fall, output mode_select, output data_in, output reset_active);
    modport dst (input rise, input fall, input mode_select, input data_in, input reset_active);
endinterface : tap_edge_if

/* src/tap_pin_sync.sv */
// Pin synchroniser and test clock edge finder
`timescale 1ns/1ps
module tap_pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic test_clock_i,
    input wire logic test_mode_select_i,
    input wire logic test_data_in_i,
    input wire logic test_reset_n_i,
    tap_edge_if.src edge_o
);
    logic [1:0] clk_sync;
    logic [1:0] tms_sync;
    logic [1:0] tdi_sync;
    logic [1:0] trst_sync;
    logic clk_prev;

    // Two stages on every pin; only stage one feeds stage two
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            clk_sync <= 2'h0;
            tms_sync <= 2'h3;
            tdi_sync <= 2'h3;
            trst_sync <= 2'h0;
        end
        else
        begin
            clk_sync <= {clk_sync[0], test_clock_i};
            tms_sync <= {tms_sync[0], test_mode_select_i};
            tdi_sync <= {tdi_sync[0], test_data_in_i};
            trst_sync <= {trst_sync[0], test_reset_n_i};
        end
    end

    // Previous synchronised clock level for edge detection
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            clk_prev <= 1'h0;
        else
            clk_prev <= clk_sync[1];
    end

    assign edge_o.rise = clk_sync[1] & ~clk_prev;
    assign edge_o.fall = ~clk_sync[1] & clk_prev;
    assign edge_o.mode_select = tms_sync[1];
    assign edge_o.data_in = tdi_sync[1];
    assign edge_o.reset_active = ~trst_sync[1];
endmodule : tap_pin_sync

/* src/tap_port.sv */
// Boundary-scan test access port controller, sampled on the system clock
`timescale 1ns/1ps
module tap_port (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic test_clock_i,
    input wire logic test_mode_select_i,
    input wire logic test_data_in_i,
    input wire logic test_reset_n_i,
    output logic test_data_out_o,
    output logic test_data_out_en_o,
    output logic test_mode_active_o,
    output logic [3:0] tap_state_o
);
    tap_edge_if pins ();
    tap_pkg::tap_state_type state;
    tap_pkg::tap_state_type next_state;
    logic [tap_pkg::IR_WIDTH-1:0] ir_shift;
    logic [tap_pkg::IR_WIDTH-1:0] ir;
    logic [tap_pkg::ID_WIDTH-1:0] id_shift;
    logic bypass_shift;
    logic next_tdo;
    logic reset_active;
    // Decoded controller conditions
    logic shift_ir;
    logic shift_dr;
    logic select_id;

    // Every pin crosses two flops before use; the price is three system cycles of
    // latency, which is why the test clock must stay at or below an eighth of clk_i
    tap_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .test_clock_i(test_clock_i),
        .test_mode_select_i(test_mode_select_i),
        .test_data_in_i(test_data_in_i),
        .test_reset_n_i(test_reset_n_i),
        .edge_o(pins)
    );

    // Test reset acts without waiting for a test clock edge (two-cycle sync delay only)
    assign reset_active = pins.reset_active;

    // Shift-state decode shared by the data paths and the output enable
    assign shift_ir = (state == tap_pkg::ST_SHIFT_IR);
    assign shift_dr = (state == tap_pkg::ST_SHIFT_DR);

    // Only the identification instruction selects the long register; every other code,
    // including the boundary ones this port does not implement, falls back to bypass
    assign select_id = (ir == tap_pkg::INSTR_IDCODE);

    // Elaboration checks on the package sizes that the shift logic relies on;
    // a mismatch here would silently cut or pad the shifted words
    generate
        if (tap_pkg::IR_WIDTH < 2)
        begin : g_ir_too_short
            $error("instruction register cannot hold the capture pattern");
        end
        if (tap_pkg::ID_WIDTH != $bits(tap_pkg::ID_VALUE))
        begin : g_id_mismatch
            $error("identification width differs from its value");
        end
        if ($bits(tap_pkg::INSTR_IDCODE) != tap_pkg::IR_WIDTH)
        begin : g_code_mismatch
            $error("instruction codes differ from the register width");
        end
    endgenerate

    // State transition table of the standard controller; unknown codes fall back
    // to the reset state so a corrupted register cannot lock the port
    always_comb
    begin
        next_state = state;
        case (state)
            tap_pkg::ST_RESET: next_state = pins.mode_select ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
            tap_pkg::ST_IDLE: next_state = pins.mode_select ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_DR: next_state = pins.mode_select ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
            tap_pkg::ST_CAP_DR: next_state = pins.mode_select ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_SHIFT_DR: next_state = pins.mode_select ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_EXIT1_DR: next_state = pins.mode_select ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_PAUSE_DR: next_state = pins.mode_select ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_EXIT2_DR: next_state = pins.mode_select ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_UPD_DR: next_state = pins.mode_select ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_IR: next_state = pins.mode_select ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
            tap_pkg::ST_CAP_IR: next_state = pins.mode_select ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_SHIFT_IR: next_state = pins.mode_select ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_EXIT1_IR: next_state = pins.mode_select ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_PAUSE_IR: next_state = pins.mode_select ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_EXIT2_IR: next_state = pins.mode_select ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_UPD_IR: next_state = pins.mode_select ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            default: next_state = tap_pkg::ST_RESET;
        endcase
    end

    // State register steps on rising test clock; held in reset while reset is low
    // Test reset outranks a rising edge in the same cycle, so no half step survives it
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            state <= tap_pkg::ST_RESET;
        else if (reset_active)
            state <= tap_pkg::ST_RESET;
        else if (pins.rise)
            state <= next_state;
    end

    // Instruction path: reset loads the identification instruction
    // The shift stage is reloaded with the reset value too, so a later update cannot apply a stale code
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ir_shift <= tap_pkg::IR_RESET_VALUE;
            ir <= tap_pkg::IR_RESET_VALUE;
        end
        else if (reset_active || state == tap_pkg::ST_RESET)
        begin
            ir <= tap_pkg::INSTR_IDCODE;
            ir_shift <= tap_pkg::IR_RESET_VALUE;
        end
        else if (pins.rise)
        begin
            if (state == tap_pkg::ST_CAP_IR)
                ir_shift <= {{(tap_pkg::IR_WIDTH-2){1'b0}}, tap_pkg::IR_CAPTURE_VALUE};
            else if (shift_ir)
                ir_shift <= {pins.data_in, ir_shift[tap_pkg::IR_WIDTH-1:1]};
            else if (state == tap_pkg::ST_UPD_IR)
                ir <= ir_shift;
        end
    end

    // Data paths: identification register and bypass bit
    // Both load on every pass through capture so either path starts from a known value
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            id_shift <= tap_pkg::ID_VALUE;
            bypass_shift <= 1'b0;
        end
        else if (pins.rise)
        begin
            if (state == tap_pkg::ST_CAP_DR)
            begin
                id_shift <= tap_pkg::ID_VALUE;
                bypass_shift <= 1'b0;
            end
            else if (shift_dr)
            begin
                // Unsupported instructions fall back to the bypass path
                if (select_id)
                    id_shift <= {pins.data_in, id_shift[tap_pkg::ID_WIDTH-1:1]};
                else
                    bypass_shift <= pins.data_in;
            end
        end
    end

    // Output bit selected from the active shift path
    // Instruction shifting takes priority, since the held instruction is still the old one
    always_comb
    begin
        if (shift_ir)
            next_tdo = ir_shift[0];
        else if (select_id)
            next_tdo = id_shift[0];
        else
            next_tdo = bypass_shift;
    end

    // Data output updates only on falling edges, or clears on test reset, so the controller samples a stable bit
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            test_data_out_o <= 1'b0;
        else if (reset_active)
            test_data_out_o <= 1'b0;
        else if (pins.fall)
            test_data_out_o <= next_tdo;
    end

    // Enable moves on the same falling edge, so the pin is driven for exactly
    // the bits that the controller reads and released half a test clock after
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            test_data_out_en_o <= 1'b0;
        else if (reset_active)
            test_data_out_en_o <= 1'b0;
        else if (pins.fall)
            test_data_out_en_o <= shift_ir || shift_dr;
    end

    // Test mode flag: low reset means normal operation; the controller
    // is expected to raise reset once after power-up before use
    // Follows the pin through the synchroniser and one more flop; no test clock is needed
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            test_mode_active_o <= 1'b0;
        else
            test_mode_active_o <= ~reset_active;
    end

    // State exported for observation
    // Registered so the port comes straight from a flop; it trails the controller by one cycle
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            tap_state_o <= tap_pkg::ST_RESET;
        else
            tap_state_o <= state;
    end
endmodule : tap_port

/* dv/tap_port_checker.sv */
// Pin-level assertions for the test access port
`timescale 1ns/1ps
module tap_port_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic test_clock_i,
    input wire logic test_mode_select_i,
    input wire logic test_reset_n_i,
    input wire logic test_data_out_o,
    input wire logic test_data_out_en_o,
    input wire logic test_mode_active_o,
    input wire logic [3:0] tap_state_o
);
    // Pins pass two sync flops and an edge flop, so effects land a few cycles late
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_trst_fall; $fell(test_reset_n_i) |-> ##[1:5] tap_state_o == 4'hF; endproperty
    a_trst_fall: assert property (p_trst_fall) else $error("test reset did not reset state");
    property p_trst_hold; !test_reset_n_i [*6] |-> tap_state_o == 4'hF && !test_data_out_en_o && !test_data_out_o; endproperty
    a_trst_hold: assert property (p_trst_hold) else $error("port active while test reset low");
    property p_mode_on; test_reset_n_i [*5] |-> test_mode_active_o; endproperty
    a_mode_on: assert property (p_mode_on) else $error("test mode not entered");
    property p_mode_off; !test_reset_n_i [*5] |-> !test_mode_active_o; endproperty
    a_mode_off: assert property (p_mode_off) else $error("normal operation not restored");
    property p_idle; tap_state_o == 4'hF && $rose(test_clock_i) && !test_mode_select_i && test_reset_n_i
        |-> ##[2:6] tap_state_o == 4'hC; endproperty
    a_idle: assert property (p_idle) else $error("no step to idle");
    property p_stay; tap_state_o == 4'hF && $rose(test_clock_i) && test_mode_select_i |-> ##6 tap_state_o == 4'hF; endproperty
    a_stay: assert property (p_stay) else $error("reset state left with select high");
    property p_sel; tap_state_o == 4'hC && $rose(test_clock_i) && test_mode_select_i && test_reset_n_i
        |-> ##[2:6] tap_state_o == 4'h7; endproperty
    a_sel: assert property (p_sel) else $error("no step to data select");
    property p_tdo_fall; $changed(test_data_out_o) && $past(test_reset_n_i, 5) && test_reset_n_i
        |-> !$past(test_clock_i, 3); endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("data out moved outside falling edge");
endmodule : tap_port_checker
bind tap_port tap_port_checker chk (.clk_i, .rst_i, .test_clock_i, .test_mode_select_i, .test_reset_n_i,
    .test_data_out_o, .test_data_out_en_o, .test_mode_active_o, .tap_state_o);

/* dv/tap_ctl_model.sv */
// Model of the external boundary-scan test controller
`timescale 1ns/1ps
module tap_ctl_model (
    input wire logic clk_i,
    input wire logic test_data_out_i,
    input wire logic test_data_out_en_i,
    output logic test_clock_o,
    output logic test_mode_select_o,
    output logic test_data_in_o,
    output logic test_reset_n_o
);
    // Clock stands low and data lines rest at pull-up level; reset held low until used
    initial
    begin
        test_clock_o = 1'b0;
        test_mode_select_o = 1'b1;
        test_data_in_o = 1'b1;
        test_reset_n_o = 1'b0;
    end
    // One test clock of 8 cycles; data out taken just before the rise, when settled
    // The output pin has no pull, so a bit read while it is released shows the inverse
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        test_mode_select_o = tms;
        test_data_in_o = tdi;
        repeat (5) @(negedge clk_i);
        tdo = test_data_out_en_i ? test_data_out_i : ~test_data_out_i;
        test_clock_o = 1'b1;
        repeat (3) @(negedge clk_i);
        test_clock_o = 1'b0;
    endtask : step
    // Low-to-high after power-up before use, low again when testing ends
    task automatic set_reset(input logic level);
        @(negedge clk_i);
        test_reset_n_o = level;
    endtask : set_reset
endmodule : tap_ctl_model

/* dv/tap_port_tb.sv */
// Self-checking testbench for the test access port
`timescale 1ns/1ps
module tap_port_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic tck, tms, tdi, trst_n, tdo, tdo_en, active;
    logic [3:0] state;
    int n_mismatch = 0;
    int num_checks = 0;
    // 50 MHz system clock
    always #10 clk_i = ~clk_i;
    tap_port dut (.clk_i(clk_i), .rst_i(rst_i), .test_clock_i(tck), .test_mode_select_i(tms),
        .test_data_in_i(tdi), .test_reset_n_i(trst_n), .test_data_out_o(tdo), .test_data_out_en_o(tdo_en),
        .test_mode_active_o(active), .tap_state_o(state));
    tap_ctl_model ctl (.clk_i(clk_i), .test_data_out_i(tdo), .test_data_out_en_i(tdo_en), .test_clock_o(tck),
        .test_mode_select_o(tms), .test_data_in_o(tdi), .test_reset_n_o(trst_n));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    // One test clock, then the state it should have reached and the enable it implies
    task automatic go(input logic m, input logic [3:0] exp);
        logic d;
        ctl.step(m, 1'b1, d);
        repeat (3) @(negedge clk_i);
        chk(state, exp);
        chk(tdo_en, exp == tap_pkg::ST_SHIFT_IR || exp == tap_pkg::ST_SHIFT_DR);
    endtask : go
    // Shift n bits LSB first, leaving on the last one
    task automatic scan(input logic [31:0] din, input int n, output logic [31:0] dout);
        logic d;
        dout = 32'h0000_0000;
        for (int i = 0; i < n; i++)
        begin
            ctl.step(i == n - 1, din[i], d);
            dout[i] = d;
        end
    endtask : scan
    task automatic t_bypass;
        logic [31:0] q;
        chk({active, state}, 5'h0F);
        ctl.set_reset(1'b1);
        repeat (6) @(negedge clk_i);
        chk(active, 1'b1);
        go(1'b0, tap_pkg::ST_IDLE);
        go(1'b1, tap_pkg::ST_SEL_DR);
        go(1'b1, tap_pkg::ST_SEL_IR);
        go(1'b0, tap_pkg::ST_CAP_IR);
        go(1'b0, tap_pkg::ST_SHIFT_IR);
        scan({28'h0, tap_pkg::INSTR_BYPASS}, 4, q);
        chk(q, 32'h1);
        go(1'b1, tap_pkg::ST_UPD_IR);
        go(1'b1, tap_pkg::ST_SEL_DR);
        go(1'b0, tap_pkg::ST_CAP_DR);
        go(1'b0, tap_pkg::ST_SHIFT_DR);
        scan(32'hA5, 8, q);
        chk(q, 32'h4A);
        go(1'b0, tap_pkg::ST_PAUSE_DR);
    endtask : t_bypass
    // Test reset dropped mid-operation, then raised to select the identification path
    task automatic t_abort;
        ctl.set_reset(1'b0);
        repeat (6) @(negedge clk_i);
        chk({tdo_en, tdo, active, state}, 7'h0F);
        ctl.set_reset(1'b1);
        repeat (6) @(negedge clk_i);
        chk({active, state}, 5'h1F);
    endtask : t_abort
    task automatic t_idcode;
        logic [31:0] q;
        go(1'b0, tap_pkg::ST_IDLE);
        go(1'b1, tap_pkg::ST_SEL_DR);
        go(1'b0, tap_pkg::ST_CAP_DR);
        go(1'b0, tap_pkg::ST_SHIFT_DR);
        scan(32'h0, 32, q);
        chk(q, tap_pkg::ID_VALUE);
        go(1'b1, tap_pkg::ST_UPD_DR);
        go(1'b1, tap_pkg::ST_SEL_DR);
        go(1'b1, tap_pkg::ST_SEL_IR);
        go(1'b1, tap_pkg::ST_RESET);
        go(1'b1, tap_pkg::ST_RESET);
    endtask : t_idcode
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    // Main sequence after 20 cycles of reset
    initial
    begin
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        t_bypass();
        t_abort();
        t_idcode();
        wrap_up();
    end
    // Whole run is near 600 cycles; cut off far beyond that
    initial
    begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
endmodule : tap_port_tb
